/* File: rtl/led_pwm_regs.svh */
`ifndef LED_PWM_REGS_SVH
`define LED_PWM_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_CONTROL           8'h00
`define REG_GROUP_DUTY        8'h04
`define REG_GROUP_PERIOD      8'h08
`define REG_OUTPUT_MODE       8'h0c
`define REG_BRIGHT_BASE       8'h10
`define REG_BRIGHT_LAST       8'h4c
`define REG_ERROR_FLAGS_LOW   8'h50
`define REG_ERROR_FLAGS_HIGH  8'h54
`define REG_IRQ_STATUS        8'h58
`define REG_IRQ_MASK          8'h5c

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_BLINK_BIT        0
`define CTRL_OT_CLEAR_BIT     1
`define IRQ_OPEN_LOAD_BIT     0
`define IRQ_OVER_TEMP_BIT     1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CONTROL_RESET         2'h0
`define GROUP_DUTY_RESET      8'hff
`define GROUP_PERIOD_RESET    8'h00
`define OUTPUT_MODE_RESET     32'h00000000
`define BRIGHT_RESET          8'h00
`define IRQ_MASK_RESET        2'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_HZ                10000000
`define PWM_STEPS             256
`define INDIV_PWM_HZ          97000
`define GROUP_DIM_HZ          190
`define BLINK_FAST_HZ         24
`define BLINK_SLOW_S          10.73
`define INDIV_STEP_RAW        (`CLK_HZ / (`INDIV_PWM_HZ * `PWM_STEPS))
`define INDIV_STEP_CYCLES     ((`INDIV_STEP_RAW > 0) ? `INDIV_STEP_RAW : 1)
`define DIM_STEP_CYCLES       (`CLK_HZ / (`GROUP_DIM_HZ * `PWM_STEPS))
`define BLINK_STEP_CYCLES     (`CLK_HZ / (`BLINK_FAST_HZ * `PWM_STEPS))

`endif

/* File: rtl/led_pwm_pkg.sv */
package led_pwm_pkg;

  // per-channel output selection
  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_ON    = 2'h1,
    MODE_INDIV = 2'h2,
    MODE_GROUP = 2'h3
  } led_mode_type;

  typedef logic [7:0] duty_type;

endpackage : led_pwm_pkg

/* File: rtl/led_channel_drive.sv */
`timescale 1ns/1ps
module led_channel_drive (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // settings
  input  wire led_pwm_pkg::led_mode_type mode,
  input  wire led_pwm_pkg::duty_type     duty,
  // shared timing
  input  wire logic [7:0]                periodCount,
  input  wire logic                      groupOut,
  input  wire logic                      shutdown,
  // sink drive
  output logic                           sinkOn
);
  import led_pwm_pkg::*;

  logic indivOut;
  logic next_sinkOn;

  always_comb begin
    indivOut = (periodCount < duty);
    case (mode)
      MODE_OFF:   next_sinkOn = 1'b0;
      MODE_ON:    next_sinkOn = 1'b1;
      MODE_INDIV: next_sinkOn = indivOut;
      MODE_GROUP: next_sinkOn = indivOut & groupOut;
      default:    next_sinkOn = 1'b0;
    endcase
    if (shutdown) begin
      next_sinkOn = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sinkOn <= 1'b0;
    end else begin
      sinkOn <= next_sinkOn;
    end
  end

endmodule : led_channel_drive

/* File: rtl/led_pwm_open_load_status.sv */
// Overview of operation
// - Every channel has its own 8-bit, 256-step brightness PWM with duty from zero to 255/256.
// - One shared 8-bit group PWM runs either at a fixed dimming rate or a programmable blink period.
// - The same group duty and period act alike on every channel in group mode.
// - A channel is open-load when its sink current is below the open-load threshold.
// - Each channel's error status is one bit of the low or high error flag register.
// - Open-load status means something only while the channel is fully on with PWM off.
// - Status is 0 when off or below threshold, and 1 when on at or above threshold.
// - The bus has no idle timeout; a hung master recovers by reset.
// - Each error flag combines open-load and overtemperature errors by OR.
// - The selected group signal is laid on top of the own brightness PWM of each channel in group mode.
`timescale 1ns/1ps
`include "led_pwm_regs.svh"
module led_pwm_open_load_status #(
  parameter int BLINK_STEP_CYCLES = `BLINK_STEP_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // current comparators and temperature sensors
  input  wire logic [15:0] currentOk,
  input  wire logic [15:0] overTempChannel,
  input  wire logic        overTempGlobal,
  // led sinks
  output logic [15:0]      ledSink,
  // interrupt
  output logic             irq
);
  import led_pwm_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam logic [23:0] INDIV_LIMIT = 24'(`INDIV_STEP_CYCLES - 1);
  localparam logic [23:0] DIM_LIMIT   = 24'(`DIM_STEP_CYCLES - 1);
  localparam logic [23:0] BLINK_STEP  = 24'(BLINK_STEP_CYCLES);

  logic                 groupBlink;
  logic [7:0]           groupDuty;
  logic [7:0]           groupPeriod;
  logic [31:0]          outputMode;
  duty_type             bright [16];
  logic [1:0]           irqMask;
  logic [1:0]           irqStatus;
  logic [15:0]          overTempErr;
  logic [15:0]          errorFlags;
  logic [15:0]          openLoadPrev;
  logic [31:0]          next_prdata;

  logic                 next_groupBlink;
  logic [7:0]           next_groupDuty;
  logic [7:0]           next_groupPeriod;
  logic [31:0]          next_outputMode;
  duty_type             next_bright [16];
  logic [1:0]           next_irqMask;
  logic [1:0]           next_irqStatus;
  logic [15:0]          next_overTempErr;
  logic [15:0]          next_errorFlags;
  logic [15:0]          next_openLoadPrev;

  logic [23:0]          indivPre;
  logic [7:0]           periodCount;
  logic [23:0]          groupPre;
  logic [7:0]           groupCount;
  logic                 groupOut;
  logic [23:0]          next_indivPre;
  logic [7:0]           next_periodCount;
  logic [23:0]          next_groupPre;
  logic [7:0]           next_groupCount;
  logic                 next_groupOut;
  logic [23:0]          groupLimit;

  logic                 setupPhase;
  logic                 writeTake;
  logic                 addrValid;
  logic                 otClear;
  logic [15:0]          channelFullOn;
  logic [15:0]          openLoadNow;
  logic [15:0]          shutdown;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  always_comb begin
    setupPhase = psel & ~penable;
    writeTake  = psel & penable & pwrite;
    pready     = psel & penable;
    addrValid  = (paddr[1:0] == 2'h0) && (paddr <= `REG_IRQ_MASK);
    pslverr    = psel & penable & ~addrValid;
    otClear    = writeTake && (paddr == `REG_CONTROL) && pwdata[`CTRL_OT_CLEAR_BIT];
  end

  always_comb begin
    next_prdata = prdata;
    if (setupPhase) begin
      next_prdata = 32'h00000000;
      case (paddr)
        `REG_CONTROL:          next_prdata = {31'h0, groupBlink};
        `REG_GROUP_DUTY:       next_prdata = {24'h0, groupDuty};
        `REG_GROUP_PERIOD:     next_prdata = {24'h0, groupPeriod};
        `REG_OUTPUT_MODE:      next_prdata = outputMode;
        `REG_ERROR_FLAGS_LOW:  next_prdata = {24'h0, errorFlags[7:0]};
        `REG_ERROR_FLAGS_HIGH: next_prdata = {24'h0, errorFlags[15:8]};
        `REG_IRQ_STATUS:       next_prdata = {30'h0, irqStatus};
        `REG_IRQ_MASK:         next_prdata = {30'h0, irqMask};
        default: begin
          if (addrValid && paddr >= `REG_BRIGHT_BASE && paddr <= `REG_BRIGHT_LAST) begin
            next_prdata = {24'h0, bright[4'(paddr[7:2] - 6'h04)]};
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always_comb begin
    next_groupBlink  = groupBlink;
    next_groupDuty   = groupDuty;
    next_groupPeriod = groupPeriod;
    next_outputMode  = outputMode;
    next_irqMask     = irqMask;
    for (int i = 0; i < 16; i++) begin
      next_bright[i] = bright[i];
    end
    if (writeTake) begin
      case (paddr)
        `REG_CONTROL:      next_groupBlink  = pwdata[`CTRL_BLINK_BIT];
        `REG_GROUP_DUTY:   next_groupDuty   = pwdata[7:0];
        `REG_GROUP_PERIOD: next_groupPeriod = pwdata[7:0];
        `REG_OUTPUT_MODE:  next_outputMode  = pwdata;
        `REG_IRQ_MASK:     next_irqMask     = pwdata[1:0];
        default: begin
          if (addrValid && paddr >= `REG_BRIGHT_BASE && paddr <= `REG_BRIGHT_LAST) begin
            next_bright[4'(paddr[7:2] - 6'h04)] = pwdata[7:0];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pwm timebases
  // ----------------------------------------------------------------------
  always_comb begin
    if (groupBlink) begin
      groupLimit = 24'(({16'h0, groupPeriod} + 24'h1) * BLINK_STEP - 24'h1);
    end else begin
      groupLimit = DIM_LIMIT;
    end
    next_indivPre    = indivPre + 24'h1;
    next_periodCount = periodCount;
    if (indivPre >= INDIV_LIMIT) begin
      next_indivPre    = 24'h0;
      next_periodCount = periodCount + 8'h01;
    end
    next_groupPre   = groupPre + 24'h1;
    next_groupCount = groupCount;
    if (groupPre >= groupLimit) begin
      next_groupPre   = 24'h0;
      next_groupCount = groupCount + 8'h01;
    end
    next_groupOut = (next_groupCount < groupDuty);
  end

  // ----------------------------------------------------------------------
  // channel status and interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      channelFullOn[i] = (led_mode_type'(outputMode[2*i +: 2]) == MODE_ON);
    end
    shutdown    = overTempChannel | {16{overTempGlobal}};
    openLoadNow = channelFullOn & ~shutdown & ~currentOk;
    next_openLoadPrev = openLoadNow;
    next_overTempErr  = otClear ? 16'h0 : overTempErr;
    next_overTempErr  = next_overTempErr | (overTempChannel & channelFullOn)
                      | {16{overTempGlobal}};
    // 1 only when fully on, current ok and no overtemperature error
    next_errorFlags = ~((~channelFullOn | openLoadNow) | overTempErr);
    next_irqStatus = irqStatus;
    if (writeTake && paddr == `REG_IRQ_STATUS) begin
      next_irqStatus = irqStatus & ~pwdata[1:0];
    end
    if (|(openLoadNow & ~openLoadPrev)) begin
      next_irqStatus[`IRQ_OPEN_LOAD_BIT] = 1'b1;
    end
    if (|shutdown) begin
      next_irqStatus[`IRQ_OVER_TEMP_BIT] = 1'b1;
    end
    irq = |(irqStatus & irqMask);
  end

  // ----------------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      groupBlink   <= 1'b0;
      groupDuty    <= `GROUP_DUTY_RESET;
      groupPeriod  <= `GROUP_PERIOD_RESET;
      outputMode   <= `OUTPUT_MODE_RESET;
      irqMask      <= `IRQ_MASK_RESET;
      irqStatus    <= 2'h0;
      overTempErr  <= 16'h0;
      errorFlags   <= 16'h0;
      openLoadPrev <= 16'h0;
      prdata       <= 32'h00000000;
      indivPre     <= 24'h0;
      periodCount  <= 8'h00;
      groupPre     <= 24'h0;
      groupCount   <= 8'h00;
      groupOut     <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        bright[i] <= `BRIGHT_RESET;
      end
    end else begin
      groupBlink   <= next_groupBlink;
      groupDuty    <= next_groupDuty;
      groupPeriod  <= next_groupPeriod;
      outputMode   <= next_outputMode;
      irqMask      <= next_irqMask;
      irqStatus    <= next_irqStatus;
      overTempErr  <= next_overTempErr;
      errorFlags   <= next_errorFlags;
      openLoadPrev <= next_openLoadPrev;
      prdata       <= next_prdata;
      indivPre     <= next_indivPre;
      periodCount  <= next_periodCount;
      groupPre     <= next_groupPre;
      groupCount   <= next_groupCount;
      groupOut     <= next_groupOut;
      for (int i = 0; i < 16; i++) begin
        bright[i] <= next_bright[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // channel drivers
  // ----------------------------------------------------------------------
  for (genvar ch = 0; ch < 16; ch++) begin : gen_channel
    led_channel_drive u_drive (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .mode        (led_mode_type'(outputMode[2*ch +: 2])),
      .duty        (bright[ch]),
      .periodCount (periodCount),
      .groupOut    (groupOut),
      .shutdown    (shutdown[ch]),
      .sinkOn      (ledSink[ch])
    );
  end

endmodule : led_pwm_open_load_status

/* File: bench/led_pwm_open_load_status_asserts.sv */
`timescale 1ns/1ps
module led_pwm_open_load_status_asserts #(
  parameter int BLINK_STEP_CYCLES = 2
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sensors, sinks, interrupt
  input wire logic [15:0] currentOk,
  input wire logic [15:0] overTempChannel,
  input wire logic        overTempGlobal,
  input wire logic [15:0] ledSink,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic bad;
  assign acc = psel && penable;
  assign bad = (paddr > 8'h5c) || (paddr[1:0] != 2'h0);
  sequence rdFlagLo;
    acc && !pwrite && paddr == 8'h50;
  endsequence
  AST_ZERO_WAIT: assert property (acc |-> pready)
    else $error("access not ready");
  AST_SLVERR: assert property (acc && bad |-> pslverr)
    else $error("bad address accepted");
  AST_NO_SLVERR: assert property (acc && !bad |-> !pslverr)
    else $error("good address refused");
  AST_RDATA_HOLD: assert property (acc && !pwrite |=> $stable(prdata))
    else $error("read data moved");
  AST_UNMAPPED_ZERO: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_FLAG_WIDTH: assert property (rdFlagLo |-> prdata[31:8] == 24'h0)
    else $error("flag upper bits set");
  AST_FLAG_CURRENT: assert property ($stable(currentOk)[*3] ##0 rdFlagLo
    |-> (prdata[7:0] & ~currentOk[7:0]) == 8'h00) else $error("flag without current");
  AST_FLAG_OVERTEMP: assert property (overTempGlobal[*4] ##0 rdFlagLo
    |-> prdata[7:0] == 8'h00) else $error("flag set in overtemperature");
  AST_SHUTDOWN: assert property (overTempGlobal[*2] |-> ledSink == 16'h0)
    else $error("sink on in shutdown");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(acc && pwrite))
    else $error("irq fell without write");
endmodule : led_pwm_open_load_status_asserts

bind led_pwm_open_load_status led_pwm_open_load_status_asserts #(
  .BLINK_STEP_CYCLES(BLINK_STEP_CYCLES)
) u_asserts (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .currentOk(currentOk),
  .overTempChannel(overTempChannel), .overTempGlobal(overTempGlobal),
  .ledSink(ledSink), .irq(irq)
);

/* File: bench/led_string_model.sv */
`timescale 1ns/1ps
module led_string_model (
  // clock
  input wire logic        clk_sys,
  // sink drive and broken strings
  input wire logic [15:0] ledSink,
  input wire logic [15:0] openMask,
  // comparator result
  output logic     [15:0] currentOk
);
  // current flows only through a driven, intact string
  always_ff @(posedge clk_sys) begin
    currentOk <= ledSink & ~openMask;
  end
endmodule : led_string_model

/* File: bench/led_pwm_open_load_status_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("Error %0t: got %h exp %h", $time, (g), (e)); end end
module led_pwm_open_load_status_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_type;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] currentOk;
  logic [15:0] overTempChannel = 16'h0;
  logic        overTempGlobal = 1'b0;
  logic [15:0] openMask = 16'h0;
  logic [15:0] ledSink;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          errors = 0;
  int          n_tests = 0;
  int          c0, c1, c2, dif;
  row_type rows[9] = '{'{8'h04, 32'h5a, 32'h5a, 1'b0}, '{8'h08, 32'h100, 32'h0, 1'b0},
    '{8'h10, 32'h40, 32'h40, 1'b0}, '{8'h4c, 32'h1ff, 32'hff, 1'b0},
    '{8'h00, 32'h3, 32'h1, 1'b0}, '{8'h5c, 32'h3, 32'h3, 1'b0},
    '{8'h0c, 32'hffffffff, 32'hffffffff, 1'b0}, '{8'h60, 32'h1, 32'h0, 1'b1},
    '{8'h52, 32'h1, 32'h0, 1'b1}};

  always #50 clk_sys = ~clk_sys;

  led_pwm_open_load_status #(.BLINK_STEP_CYCLES(2)) u_led_pwm_open_load_status (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .currentOk(currentOk),
    .overTempChannel(overTempChannel), .overTempGlobal(overTempGlobal),
    .ledSink(ledSink), .irq(irq));
  led_string_model u_led_string_model (
    .clk_sys(clk_sys), .ledSink(ledSink), .openMask(openMask), .currentOk(currentOk));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) errors++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cnt(input int n);
    c0 = 0;
    c1 = 0;
    c2 = 0;
    dif = 0;
    repeat (n) begin
      @(posedge clk_sys);
      c0 += (ledSink[0] === 1'b1);
      c1 += (ledSink[1] === 1'b1);
      c2 += (ledSink[15] === 1'b1);
      dif += (ledSink[0] !== ledSink[1]);
    end
  endtask : cnt

  // reset only between transfers
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    `CHK(ledSink, 16'h0)
    `CHK(irq, 1'b0)
    rst_n <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'hff)
  endtask : do_reset

  task automatic wrap_up;
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end

  initial begin
    do_reset();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(rd, rows[i].q)
      `CHK(er, rows[i].e)
    end
    apb(1'b1, 8'h0c, 32'h8000000a);
    repeat (4) @(posedge clk_sys);
    cnt(256);
    `CHK(c0, 64)
    `CHK(c1, 0)
    `CHK(c2, 255)
    apb(1'b1, 8'h10, 32'hff);
    apb(1'b1, 8'h14, 32'hff);
    apb(1'b1, 8'h04, 32'h80);
    apb(1'b1, 8'h0c, 32'h0f);
    repeat (4) @(posedge clk_sys);
    cnt(512);
    `CHK(c0 >= 254 && c0 <= 256, 1'b1)
    `CHK(dif, 0)
    apb(1'b1, 8'h04, 32'h0);
    repeat (4) @(posedge clk_sys);
    cnt(512);
    `CHK(c0 + c1, 0)
    openMask <= 16'h0101;
    apb(1'b1, 8'h0c, 32'h55555555);
    repeat (4) @(posedge clk_sys);
    apb(1'b0, 8'h50, 32'h0);
    `CHK(rd, 32'hfe)
    apb(1'b0, 8'h54, 32'h0);
    `CHK(rd, 32'hfe)
    `CHK(irq, 1'b1)
    apb(1'b1, 8'h58, 32'h3);
    apb(1'b1, 8'h5c, 32'h0);
    openMask <= 16'h0103;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 8'h58, 32'h0);
    `CHK(rd, 32'h1)
    `CHK(irq, 1'b0)
    apb(1'b1, 8'h5c, 32'h1);
    @(posedge clk_sys);
    `CHK(irq, 1'b1)
    apb(1'b1, 8'h58, 32'h1);
    @(posedge clk_sys);
    `CHK(irq, 1'b0)
    overTempChannel <= 16'h0008;
    repeat (3) @(posedge clk_sys);
    `CHK(ledSink[3], 1'b0)
    overTempChannel <= 16'h0;
    repeat (4) @(posedge clk_sys);
    `CHK(ledSink[3], 1'b1)
    apb(1'b0, 8'h50, 32'h0);
    `CHK(rd, 32'hf4)
    apb(1'b0, 8'h58, 32'h0);
    `CHK(rd[1], 1'b1)
    apb(1'b1, 8'h00, 32'h3);
    repeat (2) @(posedge clk_sys);
    apb(1'b0, 8'h50, 32'h0);
    `CHK(rd, 32'hfc)
    overTempGlobal <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 8'h50, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(ledSink, 16'h0)
    overTempGlobal <= 1'b0;
    apb(1'b1, 8'h00, 32'h2);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 8'h54, 32'h0);
    `CHK(rd, 32'hfe)
    apb(1'b1, 8'h0c, 32'h0000aaaa);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 8'h50, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h54, 32'h0);
    `CHK(rd, 32'h0)
    do_reset();
    wrap_up();
  end
endmodule : led_pwm_open_load_status_tb
